// ### gpp_pkg.sv
// Notes on behaviour
// - Direction bit one makes pin output.
// - Direction, level, mask reset to zero.
// - Level write drives output pin value, except on pins owned by a shared function.
// - Output pin read returns driven level.
// - Level writes to input pins ignored.
// - Input pin read returns sampled level.
// - Unmasked pin transition raises interrupt event.
// - Mask zero enables, mask one suppresses.
// - Shared functions update and read levels.
package gpp_pkg;
  localparam int GPP_PINS = 16;
  localparam logic [11:0] GPP_OFS_DIR = 12'h400;
  localparam logic [11:0] GPP_OFS_LEVEL = 12'h404;
  localparam logic [11:0] GPP_OFS_MASK = 12'h408;
  localparam logic [11:0] GPP_OFS_STATUS = 12'h40C;
  localparam logic [15:0] GPP_RST_DIR = 16'h0000;
  localparam logic [15:0] GPP_RST_LEVEL = 16'h0000;
  localparam logic [15:0] GPP_RST_MASK = 16'h0000;
  localparam logic [15:0] GPP_RST_STATUS = 16'h0000;
  localparam logic [31:0] GPP_RD_ZERO = 32'h0000_0000;
  localparam logic [15:0] GPP_UPPER_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] oe;
  } gpp_pins_out_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [15:0] level;
  } gpp_share_t;

  typedef struct packed {
    logic [15:0] meta;
    logic [15:0] sync;
  } gpp_sync_t;

  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] level_out;
    logic [15:0] mask;
    logic [15:0] status;
    logic [15:0] prev_in;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    gpp_pins_out_t pins;
  } gpp_state_t;
endpackage

// ### gpp_sync.sv
`timescale 1ns/1ns
module gpp_sync
  import gpp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw and synchronised levels
  input wire logic [15:0] raw_in,
  output logic [15:0] sync_out
);
  gpp_sync_t st;
  gpp_sync_t next_st;

  always_comb begin
    next_st.meta = raw_in;
    next_st.sync = st.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.sync;
endmodule

// ### gpp_port.sv
`timescale 1ns/1ns
module gpp_port
  import gpp_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // General purpose pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  // Shared serial and local bus functions
  input wire logic [15:0] share_sel,
  input wire logic [15:0] share_level,
  output logic [15:0] share_in
);
  gpp_state_t st;
  gpp_state_t next_st;
  logic [15:0] pin_sync;
  logic [15:0] wr_data;
  logic [15:0] rd_level;
  logic [15:0] edges;
  logic wr_en;
  logic rd_en;

  gpp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(pin_in),
    .sync_out(pin_sync)
  );

  // Byte lanes merged into the low sixteen bits
  always_comb begin
    wr_data = pwdata[15:0];
    if (!pstrb[0]) begin
      wr_data[7:0] = 8'h00;
    end
    if (!pstrb[1]) begin
      wr_data[15:8] = 8'h00;
    end
  end

  assign wr_en = psel && penable && pwrite && !st.pready;
  assign rd_en = psel && penable && !pwrite && !st.pready;
  assign edges = pin_sync ^ st.prev_in;

  // Per pin read-back: output pins show driven level, inputs show pin
  genvar gi;
  generate
    for (gi = 0; gi < GPP_PINS; gi++) begin : g_pin
      assign rd_level[gi] = st.dir[gi] ? st.pins.value[gi] : pin_sync[gi];
    end
  endgenerate

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction

  always_comb begin
    logic [15:0] lvl_merged;
    lvl_merged = lane_merge(st.level_out, wr_data, pstrb);
    next_st = st;
    next_st.prev_in = pin_sync;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // Shared functions own the level of their selected output pins
    next_st.level_out = (st.level_out & ~(share_sel & st.dir)) | (share_level & share_sel & st.dir);
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
    end
    if (wr_en) begin
      if (paddr == GPP_OFS_DIR) begin
        next_st.dir = lane_merge(st.dir, wr_data, pstrb);
      end else if (paddr == GPP_OFS_LEVEL) begin
        // Only output pins not owned by a shared function take the write
        next_st.level_out = (next_st.level_out & ~(st.dir & ~share_sel))
                            | (lvl_merged & st.dir & ~share_sel);
      end else if (paddr == GPP_OFS_MASK) begin
        next_st.mask = lane_merge(st.mask, wr_data, pstrb);
      end else if (paddr == GPP_OFS_STATUS) begin
        next_st.status = st.status & ~(wr_data & {{8{pstrb[1]}}, {8{pstrb[0]}}});
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    // Hardware set wins over a write-one clear in the same cycle
    next_st.status = next_st.status | (edges & ~st.mask);
    if (rd_en) begin
      if (paddr == GPP_OFS_DIR) begin
        next_st.prdata = {GPP_UPPER_ZERO, st.dir};
      end else if (paddr == GPP_OFS_LEVEL) begin
        next_st.prdata = {GPP_UPPER_ZERO, rd_level};
      end else if (paddr == GPP_OFS_MASK) begin
        next_st.prdata = {GPP_UPPER_ZERO, st.mask};
      end else if (paddr == GPP_OFS_STATUS) begin
        next_st.prdata = {GPP_UPPER_ZERO, st.status};
      end else begin
        next_st.prdata = GPP_RD_ZERO;
        next_st.pslverr = 1'b1;
      end
    end
    next_st.pins.oe = next_st.dir;
    next_st.pins.value = next_st.level_out;
    next_st.irq = |(next_st.status & ~next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.dir <= GPP_RST_DIR;
      st.level_out <= GPP_RST_LEVEL;
      st.mask <= GPP_RST_MASK;
      st.status <= GPP_RST_STATUS;
      st.prev_in <= GPP_RST_LEVEL;
      st.prdata <= GPP_RD_ZERO;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.irq <= 1'b0;
      st.pins <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign pin_out = st.pins.value;
  assign pin_oe = st.pins.oe;
  assign share_in = st.prev_in;
endmodule

// ### gpp_chk.sv
`timescale 1ns/1ns
module gpp_chk
  import gpp_pkg::*;
(
  // APB and interrupt
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins
  input wire logic [15:0] pin_in, pin_out, pin_oe, share_sel, share_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk, hole;
  assign tk = psel && penable && !pready;
  assign hole = !(paddr inside {GPP_OFS_DIR, GPP_OFS_LEVEL, GPP_OFS_MASK, GPP_OFS_STATUS});
  a_oe_dir: assert property (tk && pwrite && paddr == GPP_OFS_DIR
    |-> ##2 pin_oe == $past(pwdata[15:0], 2)) else $error("oe wrong");
  a_level_pin: assert property (tk && pwrite && paddr == GPP_OFS_LEVEL
    |-> ##2 ((pin_out ^ $past(pwdata[15:0], 2)) & pin_oe & ~share_sel) == 16'h0000) else $error("pin wrong");
  a_one_wait: assert property (tk |=> pready ##1 !pready) else $error("pready wrong");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == GPP_UPPER_ZERO) else $error("upper");
  a_err_hole: assert property (tk |=> pslverr == $past(hole)) else $error("pslverr wrong");
  a_hole_zero: assert property (tk && hole && !pwrite |=> prdata == GPP_RD_ZERO) else $error("hole data");
  a_mask_quiet: assert property (tk && pwrite && paddr == GPP_OFS_MASK && pwdata[15:0] == 16'hFFFF
    |-> ##2 !irq [*3]) else $error("irq masked");
  a_sync_delay: assert property (share_in == $past(pin_in, 3)) else $error("sync delay");
  cover property (tk && hole);
  cover property ($rose(irq));
  cover property (tk && pwrite && paddr == GPP_OFS_LEVEL);
endmodule
bind gpp_port gpp_chk i_chk (.*);

// ### gpp_pins_model.sv
`timescale 1ns/1ns
module gpp_pins_model (
  // Pins
  input wire logic [15:0] ext, pin_out, pin_oe,
  output logic [15:0] pin_in
);
  // Driven pins read back what the port drives
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

// ### gpp_port_test.sv
`timescale 1ns/1ns
module gpp_port_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] ext = 16'h0, share_sel = 16'h0, share_level = 16'h0, pin_in, pin_out, pin_oe, share_in;
  logic e;
  int miscompares = 0, num_checks = 0;
  always #25 pclk = ~pclk;
  gpp_port i_dut (.*);
  gpp_pins_model i_pins (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  task automatic conclude;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look at pready between edges, where it has settled, then take the edge that samples it
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic t_regs;
    rd(12'h400, 32'h0);
    rd(12'h404, 32'h0);
    rd(12'h408, 32'h0);
    apb(1'b1, 12'h400, 32'hFFFF_00FF);
    apb(1'b1, 12'h408, 32'h0000_00FF);
    apb(1'b1, 12'h404, 32'hFFFF_FFA5);
    rd(12'h400, 32'h0000_00FF);
    rd(12'h404, 32'h0000_00A5);
    chk({16'h0, pin_out & pin_oe}, 32'h0000_00A5);
    chk({16'h0, pin_oe}, 32'h0000_00FF);
    apb(1'b1, 12'h400, 32'h0000_FFFF);
    rd(12'h404, 32'h0000_00A5);
    apb(1'b1, 12'h400, 32'h0000_00FF);
  endtask
  task automatic t_events;
    apb(1'b1, 12'h40C, 32'h0000_FFFF);
    ext <= 16'h0100;
    repeat (5) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(12'h404, 32'h0000_01A5);
    chk({16'h0, share_in}, 32'h0000_01A5);
    apb(1'b1, 12'h40C, 32'h0000_0100);
    rd(12'h40C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h408, 32'h0000_FFFF);
    ext <= 16'h0000;
    repeat (5) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(12'h40C, 32'h0);
  endtask
  task automatic t_misc;
    rd(12'h410, 32'h0);
    chk({31'h0, e}, 32'h1);
    share_sel <= 16'h0001;
    repeat (3) @(posedge pclk);
    apb(1'b1, 12'h404, 32'h0000_00A5);
    rd(12'h404, 32'h0000_00A4);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_events();
    t_misc();
    conclude();
  end
endmodule
